// ==== src/prox_adc_cfg.v ====
// adc input configuration registers and recovery timer for the light/proximity sequencer
// assumes one ahb-lite master, single word transfers, adc results from logic on hclk
//
// The AHB-Lite slave port was decided locally.
`include "prox_adc_cfg_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module prox_adc_cfg (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        meas_start,
  input  wire [1:0]  meas_chan,
  input  wire [16:0] adc_raw,
  input  wire        adc_valid,
  output reg  [16:0] ambient_vis_out,
  output reg  [16:0] ambient_ir_out,
  output reg  [2:0]  adc_source,
  output reg         recovery_busy,
  output reg         convert_go,
  output reg         led_drive_allow,
  output reg  [3:0]  integ_scale_log2
);

  // meas_chan: 0..2 proximity 1..3, 3 = ambient; ambient pair taken from adc_raw on adc_valid
  localparam ST_IDLE = 2'd0;
  localparam ST_REC  = 2'd1;
  localparam ST_CONV = 2'd2;

  reg  [7:0]  align_r;
  wire [7:0]  sel_r [0:2];
  wire [2:0]  src_each [0:2];
  reg  [19:0] rec_base;
  reg  [31:0] rec_wide;
  reg  [7:0]  recov_r;
  reg  [7:0]  gain_r;
  reg         mode_r;
  reg  [1:0]  state_r;
  reg  [1:0]  chan_r;
  reg  [19:0] cnt_r;
  reg  [19:0] cnt_nxt;
  reg         wr_pend_r;
  reg  [7:0]  wr_addr_r;
  reg  [31:0] rd_nxt;
  reg  [2:0]  src_nxt;
  reg         amb_vis_sel_r;
  wire        take;
  wire [2:0]  rcode;

  assign take  = hsel && hready && htrans[1];
  assign rcode = recov_r[6:4];

  // one selector register and one code decoder per proximity channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_chan
      reg [7:0] sel_q_r;
      reg [2:0] src_dec;
      assign sel_r[g]    = sel_q_r;
      assign src_each[g] = src_dec;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sel_q_r <= `SEL_RST;
        end else if (wr_pend_r && wr_addr_r == (`P1SEL_OFS + 8'h04 * g)) begin
          sel_q_r <= hwdata[7:0];
        end
      end
      // raw-only codes fall to none in normal mode
      always @* begin
        src_dec = `SRC_NONE;
        if (sel_q_r == `SEL_LARGE_IR) begin
          src_dec = `SRC_LARGE_IR;
        end else if (sel_q_r == `SEL_SMALL_IR) begin
          src_dec = `SRC_SMALL_IR;
        end else if (!mode_r) begin
          if (sel_q_r == `SEL_VISIBLE) begin
            src_dec = `SRC_VISIBLE;
          end else if (sel_q_r == `SEL_NO_PD) begin
            src_dec = `SRC_NO_PD;
          end else if (sel_q_r == `SEL_GND) begin
            src_dec = `SRC_GND;
          end else if (sel_q_r == `SEL_TEMP) begin
            src_dec = `SRC_TEMP;
          end else if (sel_q_r == `SEL_VDD) begin
            src_dec = `SRC_VDD;
          end
        end
      end
    end
  endgenerate

  always @* begin
    src_nxt = src_each[chan_r];
  end

  // recovery length from a table, not a shift, so code 7 cannot wrap
  always @* begin
    case (rcode)
      3'd0: rec_base = `REC_CLK_0;
      3'd1: rec_base = `REC_CLK_1;
      3'd2: rec_base = `REC_CLK_2;
      3'd3: rec_base = `REC_CLK_3;
      3'd4: rec_base = `REC_CLK_4;
      3'd5: rec_base = `REC_CLK_5;
      3'd6: rec_base = `REC_CLK_6;
      default: rec_base = `REC_CLK_7;
    endcase
    rec_wide = rec_base * `ADC_CLK_CYC;
    cnt_nxt  = rec_wide[19:0] << gain_r[2:0];
  end

  // readback with reserved bits as zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (haddr == `ALIGN_OFS) begin
      rd_nxt[7:0] = align_r;
    end else if (haddr == `P1SEL_OFS) begin
      rd_nxt[7:0] = sel_r[0];
    end else if (haddr == `P2SEL_OFS) begin
      rd_nxt[7:0] = sel_r[1];
    end else if (haddr == `P3SEL_OFS) begin
      rd_nxt[7:0] = sel_r[2];
    end else if (haddr == `RECOV_OFS) begin
      rd_nxt[7:0] = recov_r;
    end else if (haddr == `GAIN_OFS) begin
      rd_nxt[7:0] = gain_r;
    end else if (haddr == `MODE_OFS) begin
      rd_nxt[0] = mode_r;
    end else if (haddr == `SEQ_OFS) begin
      rd_nxt[19:0] = cnt_r;
    end else if (haddr == `STAT_OFS) begin
      rd_nxt[5:0] = {adc_source, state_r, recovery_busy};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      align_r   <= `ALIGN_RST;
      recov_r   <= `RECOV_RST;
      gain_r    <= `GAIN_RST;
      mode_r    <= `MODE_RST;
    end else begin
      // zero wait state slave; unmapped reads give zero, writes dropped
      wr_pend_r <= take && hwrite;
      if (take) begin
        wr_addr_r <= haddr;
      end
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
      if (wr_pend_r) begin
        if (wr_addr_r == `ALIGN_OFS) begin
          align_r <= hwdata[7:0] & `ALIGN_MASK;
        end else if (wr_addr_r == `RECOV_OFS) begin
          recov_r <= hwdata[7:0] & `RECOV_MASK;
        end else if (wr_addr_r == `GAIN_OFS) begin
          gain_r <= hwdata[7:0] & `GAIN_MASK;
        end else if (wr_addr_r == `MODE_OFS) begin
          mode_r <= hwdata[`MODE_BIT];
        end
      end
    end
  end

  // proximity sequencer: recovery wait then conversion
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r          <= ST_IDLE;
      chan_r           <= 2'd0;
      cnt_r            <= 20'd0;
      adc_source       <= `SRC_NONE;
      recovery_busy    <= 1'b0;
      convert_go       <= 1'b0;
      led_drive_allow  <= 1'b0;
      integ_scale_log2 <= 4'd0;
      amb_vis_sel_r    <= 1'b0;
      ambient_vis_out  <= 17'd0;
      ambient_ir_out   <= 17'd0;
    end else begin
      convert_go       <= 1'b0;
      integ_scale_log2 <= {1'b0, gain_r[2:0]};
      case (state_r)
        ST_IDLE: begin
          led_drive_allow <= 1'b0;
          if (meas_start && meas_chan != 2'd3) begin
            chan_r        <= meas_chan;
            cnt_r         <= cnt_nxt;
            recovery_busy <= 1'b1;
            state_r       <= ST_REC;
          end else if (meas_start) begin
            amb_vis_sel_r <= ~amb_vis_sel_r;
          end
        end
        ST_REC: begin
          adc_source <= src_nxt;
          if (cnt_r <= 20'd1) begin
            recovery_busy   <= 1'b0;
            convert_go      <= 1'b1;
            led_drive_allow <= mode_r;
            state_r         <= ST_CONV;
          end else begin
            cnt_r <= cnt_r - 20'd1;
          end
        end
        ST_CONV: begin
          if (adc_valid) begin
            led_drive_allow <= 1'b0;
            state_r         <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // ambient results: 17-bit field, low 16 or upper 16 bits by alignment
      if (adc_valid && state_r == ST_IDLE) begin
        if (amb_vis_sel_r) begin
          ambient_vis_out <= align_r[`VIS_ALIGN_BIT] ? {1'b0, adc_raw[15:0]}
                                                     : {1'b0, adc_raw[16:1]};
        end else begin
          ambient_ir_out <= align_r[`IR_ALIGN_BIT] ? {1'b0, adc_raw[15:0]}
                                                   : {1'b0, adc_raw[16:1]};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/prox_adc_cfg_defines.vh ====
// offsets, field positions, reset values and timing for the adc input configuration block
// assumes inclusion by bare name from the design file
`ifndef PROX_ADC_CFG_DEFINES_VH
`define PROX_ADC_CFG_DEFINES_VH

`define ALIGN_OFS        8'h18
`define P1SEL_OFS        8'h1c
`define P2SEL_OFS        8'h20
`define P3SEL_OFS        8'h24
`define RECOV_OFS        8'h28
`define GAIN_OFS         8'h2c
`define MODE_OFS         8'h30
`define SEQ_OFS          8'h34
`define STAT_OFS         8'h38

`define ALIGN_IDX        8'h06
`define P1SEL_IDX        8'h07
`define P2SEL_IDX        8'h08
`define P3SEL_IDX        8'h09
`define RECOV_IDX        8'h0a

`define VIS_ALIGN_BIT    5
`define IR_ALIGN_BIT     4
`define ALIGN_MASK       8'h30
`define RECOV_MASK       8'h70
`define GAIN_MASK        8'h07
`define MODE_BIT         0

`define ALIGN_RST        8'h00
`define SEL_RST          8'h03
`define RECOV_RST        8'h70
`define GAIN_RST         8'h00
`define MODE_RST         1'b1

`define SEL_SMALL_IR     8'h00
`define SEL_VISIBLE      8'h02
`define SEL_LARGE_IR     8'h03
`define SEL_NO_PD        8'h06
`define SEL_GND          8'h25
`define SEL_TEMP         8'h65
`define SEL_VDD          8'h75

`define SRC_NONE         3'h0
`define SRC_SMALL_IR     3'h1
`define SRC_LARGE_IR     3'h2
`define SRC_VISIBLE      3'h3
`define SRC_NO_PD        3'h4
`define SRC_GND          3'h5
`define SRC_TEMP         3'h6
`define SRC_VDD          3'h7

`define REC_CLK_0        20'd1
`define REC_CLK_1        20'd7
`define REC_CLK_2        20'd15
`define REC_CLK_3        20'd31
`define REC_CLK_4        20'd63
`define REC_CLK_5        20'd127
`define REC_CLK_6        20'd255
`define REC_CLK_7        20'd511

`define ADC_CLK_NS       50
`define HCLK_NS          50
`define ADC_CLK_CYC      ((`ADC_CLK_NS + `HCLK_NS - 1) / `HCLK_NS)

`endif

// ==== verification/adc_model.sv ====
// adc model: answers convert_go with a fixed result
// assumes convert_go and amb_go are one-cycle pulses on hclk
// reference subtraction and negation stay with host software
`timescale 1ns/10ps
`default_nettype none
module adc_model #(parameter logic [16:0] RAW = 17'h0) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        convert_go,
  input wire logic        amb_go,
  input wire logic        slow,
  output var logic [16:0] adc_raw,
  output var logic        adc_valid
);
  logic [3:0] wait_r;
  logic       armed_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {armed_r, wait_r, adc_valid, adc_raw} <= '0;
    end else begin
      adc_valid <= 1'b0;
      // flips so a stale sample cannot pass
      adc_raw <= ~adc_raw;
      if (convert_go || amb_go) begin
        armed_r <= 1'b1;
        wait_r <= slow ? 4'h9 : 4'h0;
      end else if (armed_r && wait_r == 4'h0) begin
        armed_r <= 1'b0;
        adc_valid <= 1'b1;
        adc_raw <= RAW;
      end else if (armed_r) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/prox_adc_cfg_sva.sv ====
// port assertions for the adc input configuration block
// assumes hready is the looped back hreadyout
`timescale 1ns/10ps
`default_nettype none
module prox_adc_cfg_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        meas_start,
  input wire logic [1:0]  meas_chan,
  input wire logic [16:0] ambient_vis_out,
  input wire logic [16:0] ambient_ir_out,
  input wire logic        recovery_busy,
  input wire logic        convert_go,
  input wire logic        led_drive_allow
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [19:0] busy_n;
  // longest wait is 511 clocks times 2^7
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) busy_n <= 20'h0;
    else busy_n <= recovery_busy ? busy_n + 20'h1 : 20'h0;
  end
  sequence s_rd_hole;
    hsel && hready && htrans[1] && !hwrite && haddr == 8'h3c;
  endsequence
  sequence s_start;
    meas_start && meas_chan != 2'd3 && !recovery_busy && !convert_go && !led_drive_allow;
  endsequence
  sequence s_recov_end;
    recovery_busy ##1 !recovery_busy;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_hole_zero: assert property (s_rd_hole |=> hrdata == 32'h0)
    else $error("hole not zero");
  a_start_busy: assert property (s_start |=> recovery_busy)
    else $error("no recovery");
  a_recov_go: assert property (s_recov_end |-> convert_go)
    else $error("no go");
  a_go_pulse: assert property (convert_go |=> !convert_go)
    else $error("go too long");
  a_recov_max: assert property (recovery_busy |-> busy_n < 20'd65408)
    else $error("recovery too long");
  a_no_led: assert property (recovery_busy |-> !led_drive_allow)
    else $error("led in recovery");
  a_align_msb: assert property (!ambient_vis_out[16] && !ambient_ir_out[16])
    else $error("ambient over 16 bits");
endmodule
bind prox_adc_cfg prox_adc_cfg_sva u_prox_adc_cfg_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .meas_start, .meas_chan,
  .ambient_vis_out,
  .ambient_ir_out, .recovery_busy, .convert_go, .led_drive_allow);
`default_nettype wire

// ==== verification/prox_adc_cfg_test.sv ====
// bench for the adc input configuration block
// assumes checker and adc model are compiled first
`timescale 1ns/10ps
`include "prox_adc_cfg_defines.vh"
`default_nettype none
module prox_adc_cfg_test;
  localparam logic [16:0] RAW = 17'h1a5c3;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, meas_start = 0, slow = 0, led_seen;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0, meas_chan = 0;
  logic [2:0]  hsize = 3'h2, src_seen;
  logic [31:0] hwdata = 0, rd;
  wire logic hready, hreadyout, hresp, recovery_busy, convert_go, led_drive_allow, adc_valid;
  wire logic [31:0] hrdata;
  wire logic [16:0] adc_raw, ambient_vis_out, ambient_ir_out;
  wire logic [2:0]  adc_source;
  wire logic [3:0]  integ_scale_log2;
  int fails = 0, num_checks = 0, ticks = 0, n;
  logic [7:0] adr[7] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
  logic [7:0] rst[7] = '{8'h00, 8'h03, 8'h03, 8'h03, 8'h70, 8'h00, 8'h01};
  logic [7:0] msk[7] = '{8'h30, 8'hff, 8'hff, 8'hff, 8'h70, 8'h07, 8'h01};
  logic [7:0] code[8] = '{8'h03, 8'h00, 8'h02, 8'h02, 8'h06, 8'h25, 8'h65, 8'h75};
  logic [2:0] src[8] = '{3'h2, 3'h1, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [2:0] rc[4] = '{3'h0, 3'h7, 3'h2, 3'h1};
  logic [2:0] gn[4] = '{3'h0, 3'h0, 3'h5, 3'h1};
  assign hready = hreadyout;
  prox_adc_cfg u_prox_adc_cfg (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .meas_start, .meas_chan, .adc_raw,
    .adc_valid, .ambient_vis_out, .ambient_ir_out, .adc_source, .recovery_busy,
    .convert_go, .led_drive_allow, .integ_scale_log2);
  adc_model #(.RAW(RAW)) u_adc_model (.hclk, .hresetn, .convert_go,
    .amb_go(meas_start && meas_chan == 2'd3), .slow, .adc_raw, .adc_valid);
  initial forever #25 hclk = ~hclk;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // counts busy cycles up to the go pulse, then waits for the result
  task automatic meas(input logic [1:0] ch);
    meas_chan <= ch;
    meas_start <= 1'b1;
    n = 0;
    @(posedge hclk);
    meas_start <= 1'b0;
    while (ch != 2'd3 && convert_go !== 1'b1) begin
      n += int'(recovery_busy === 1'b1);
      @(posedge hclk);
    end
    src_seen = adc_source;
    led_seen = led_drive_allow;
    while (adc_valid !== 1'b1) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      xfer(0, adr[i], 0);
      chk("reset", rd, rst[i]);
      xfer(1, adr[i], 32'hffffffff);
      xfer(0, adr[i], 0);
      chk("mask", rd, msk[i]);
    end
    xfer(0, 8'h3c, 0);
    chk("hole", rd, 0);
    xfer(1, `GAIN_OFS, 0);
    xfer(1, `RECOV_OFS, 0);
    for (int i = 0; i < 8; i++) begin
      xfer(1, `MODE_OFS, i < 3);
      xfer(1, `P1SEL_OFS + 8'(4 * (i % 3)), code[i]);
      meas(2'(i % 3));
      chk("source", src_seen, src[i]);
      chk("led", led_seen, i < 3);
    end
    for (int i = 0; i < 4; i++) begin
      // third case is gain 5 with its complement as recovery code
      xfer(1, `GAIN_OFS, gn[i]);
      xfer(1, `RECOV_OFS, {rc[i], 4'h0});
      meas(2'd1);
      chk("recovery", n, (rc[i] == 0 ? 1 : (1 << (rc[i] + 2)) - 1) << gn[i]);
      chk("scale", integ_scale_log2, gn[i]);
    end
    slow <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      xfer(1, `ALIGN_OFS, i ? 32'h10 : 32'h20);
      meas(2'd3);
      meas(2'd3);
      chk("vis", ambient_vis_out, i ? RAW[16:1] : RAW[15:0]);
      chk("ir", ambient_ir_out, i ? RAW[15:0] : RAW[16:1]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
